//--- opd_decoder.sv
// Operation-code decoder: registers a fetched code and emits its operation
`timescale 1ns/1ps
module opd_decoder (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Fetch side
    input wire logic fetch_valid,
    input wire logic [7:0] opcode,
    input wire logic irq_pending,
    // Decoded outputs
    output logic dec_valid,
    output opd_pkg::opd_op_type dec_op,
    output opd_pkg::opd_mode_type dec_mode,
    output logic [3:0] dec_row,
    output logic [3:0] dec_col,
    output logic halted,
    output logic stopped
);
    typedef struct packed {
        logic valid;
        opd_pkg::opd_op_type op;
        opd_pkg::opd_mode_type mode;
        logic [3:0] row;
        logic [3:0] col;
        opd_pkg::opd_state_type st;
    } opd_state_struct_type;

    opd_state_struct_type s_q;
    opd_state_struct_type s_d;
    logic [3:0] row_w;
    logic [3:0] col_w;
    opd_pkg::opd_op_type op_w;
    opd_pkg::opd_mode_type mode_w;

    // Row and column split
    opd_row_col u_split (
        .opcode(opcode),
        .row(row_w),
        .col(col_w)
    );

    // Matrix lookup
    opd_table u_table (
        .row(row_w),
        .col(col_w),
        .op(op_w),
        .mode(mode_w)
    );

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        case (s_q.st)
            opd_pkg::OPD_ST_RUN: begin
                if (fetch_valid) begin
                    s_d.valid = 1'b1;
                    s_d.op = op_w;
                    s_d.mode = mode_w;
                    s_d.row = row_w;
                    s_d.col = col_w;
                    if (op_w == opd_pkg::OPD_OP_HALT_UNTIL_IRQ) begin
                        s_d.st = opd_pkg::OPD_ST_HALT;
                    end else if (op_w == opd_pkg::OPD_OP_STOP_UNTIL_RESET) begin
                        s_d.st = opd_pkg::OPD_ST_STOP;
                    end
                end
            end
            opd_pkg::OPD_ST_HALT: begin
                if (irq_pending) begin
                    s_d.st = opd_pkg::OPD_ST_RUN;
                end
            end
            opd_pkg::OPD_ST_STOP: s_d.st = opd_pkg::OPD_ST_STOP;
            default: s_d.st = opd_pkg::OPD_ST_RUN;
        endcase
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q.valid <= 1'b0;
            s_q.op <= opd_pkg::OPD_OP_NOP;
            s_q.mode <= opd_pkg::OPD_AM_IMPLIED;
            s_q.row <= 4'h0;
            s_q.col <= 4'h0;
            s_q.st <= opd_pkg::OPD_ST_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign dec_valid = s_q.valid;
    assign dec_op = s_q.op;
    assign dec_mode = s_q.mode;
    assign dec_row = s_q.row;
    assign dec_col = s_q.col;
    assign halted = s_q.st[1]; // One-hot bit of the halt state
    assign stopped = s_q.st[2]; // One-hot bit of the stop state
endmodule

//--- opd_decoder_bench.sv
// Self-checking bench for the operation-code decoder
`timescale 1ns/1ps
module opd_decoder_bench;
    // ==========================================
    // Signals and instances
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic irq_pending = 1'b0;
    logic fetch_valid;
    logic [7:0] opcode;
    logic dec_valid;
    logic halted;
    logic stopped;
    opd_pkg::opd_op_type dec_op;
    opd_pkg::opd_mode_type dec_mode;
    logic [3:0] dec_row;
    logic [3:0] dec_col;
    int failures = 0;
    int checks = 0;
    always #5 clock = ~clock;
    opd_mem_model u_opd_mem_model (.fetch_valid(fetch_valid), .opcode(opcode));
    opd_decoder u_opd_decoder (.clock(clock), .rst_n(rst_n), .fetch_valid(fetch_valid),
        .opcode(opcode), .irq_pending(irq_pending), .dec_valid(dec_valid), .dec_op(dec_op),
        .dec_mode(dec_mode), .dec_row(dec_row), .dec_col(dec_col), .halted(halted),
        .stopped(stopped));
    // ==========================================
    // Shared tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Present a code, release the bus, wait for the answer
    task automatic dec(input logic [7:0] c, input opd_pkg::opd_op_type op);
        int n;
        @(negedge clock);
        u_opd_mem_model.put(c);
        @(negedge clock);
        u_opd_mem_model.idle();
        for (n = 0; n < 4 && dec_valid !== 1'b1; n++) begin
            @(negedge clock);
        end
        if (n == 4) begin
            failures++;
            summarize();
        end else begin
            check("op", dec_op, op);
            check("row col", {dec_row, dec_col}, c);
        end
    endtask
    // Codes packed first-listed in the highest byte
    task automatic dec_list(input logic [79:0] cs, input int n, input opd_pkg::opd_op_type op);
        for (int i = n - 1; i >= 0; i--) begin
            dec(cs[i*8 +: 8], op);
        end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        dec(8'haa, opd_pkg::OPD_OP_COPY_ACC_TO_X);
        check("mode", 8'(dec_mode), 8'(opd_pkg::OPD_AM_IMPLIED));
        dec(8'ha8, opd_pkg::OPD_OP_COPY_ACC_TO_Y);
        dec(8'hba, opd_pkg::OPD_OP_COPY_SP_TO_X);
        dec(8'h8a, opd_pkg::OPD_OP_COPY_X_TO_ACC);
        dec(8'h9a, opd_pkg::OPD_OP_COPY_X_TO_SP);
        dec(8'h98, opd_pkg::OPD_OP_COPY_Y_TO_ACC);
        dec(8'hda, opd_pkg::OPD_OP_PUSH_X_INDEX);
        check("mode", 8'(dec_mode), 8'(opd_pkg::OPD_AM_STACK));
        dec(8'h5a, opd_pkg::OPD_OP_PUSH_Y_INDEX);
        dec(8'hfa, opd_pkg::OPD_OP_PULL_X_INDEX);
        dec(8'h7a, opd_pkg::OPD_OP_PULL_Y_INDEX);
        dec(8'h78, opd_pkg::OPD_OP_SET_IRQ_DISABLE);
        $display("register codes done");
    endtask
    task automatic t_mem();
        dec_list({8'h64, 8'h74, 8'h9c, 8'h9e}, 4, opd_pkg::OPD_OP_STORE_ZERO);
        check("mode", 8'(dec_mode), 8'(opd_pkg::OPD_AM_ABS_X));
        dec_list({8'h14, 8'h1c}, 2, opd_pkg::OPD_OP_TEST_AND_CLEAR_BITS);
        check("mode", 8'(dec_mode), 8'(opd_pkg::OPD_AM_ABS));
        dec(8'h14, opd_pkg::OPD_OP_TEST_AND_CLEAR_BITS);
        check("mode", 8'(dec_mode), 8'(opd_pkg::OPD_AM_ZP));
        dec_list({8'h04, 8'h0c}, 2, opd_pkg::OPD_OP_TEST_AND_SET_BITS);
        dec_list({8'h2a, 8'h26, 8'h36, 8'h2e, 8'h3e}, 5, opd_pkg::OPD_OP_ROTATE_LEFT);
        check("mode", 8'(dec_mode), 8'(opd_pkg::OPD_AM_ABS_X));
        dec(8'h2a, opd_pkg::OPD_OP_ROTATE_LEFT);
        check("mode", 8'(dec_mode), 8'(opd_pkg::OPD_AM_ACCUM));
        dec_list({8'h6a, 8'h66, 8'h76, 8'h6e, 8'h7e}, 5, opd_pkg::OPD_OP_ROTATE_RIGHT);
        dec_list({8'he1, 8'he5, 8'he9, 8'hed, 8'hf1, 8'hf2, 8'hf5, 8'hf9, 8'hfd}, 9,
            opd_pkg::OPD_OP_SUBTRACT_WITH_BORROW);
        dec_list({8'h81, 8'h85, 8'h8d, 8'h91, 8'h95, 8'h99, 8'h9d, 8'h92}, 8,
            opd_pkg::OPD_OP_STORE_ACCUMULATOR);
        check("mode", 8'(dec_mode), 8'(opd_pkg::OPD_AM_ZP_IND));
        dec_list({8'h86, 8'h96, 8'h8e}, 3, opd_pkg::OPD_OP_STORE_X_INDEX);
        check("mode", 8'(dec_mode), 8'(opd_pkg::OPD_AM_ABS));
        dec(8'h96, opd_pkg::OPD_OP_STORE_X_INDEX);
        check("mode", 8'(dec_mode), 8'(opd_pkg::OPD_AM_ZP_Y));
        dec_list({8'h84, 8'h94, 8'h8c}, 3, opd_pkg::OPD_OP_STORE_Y_INDEX);
        $display("memory codes done");
    endtask
    task automatic t_nop();
        for (int r = 0; r < 16; r++) begin
            dec({r[3:0], 4'h3}, opd_pkg::OPD_OP_NOP);
        end
        // Two codes in adjacent cycles
        @(negedge clock);
        u_opd_mem_model.put(8'haa);
        @(negedge clock);
        u_opd_mem_model.put(8'h5a);
        check("op", dec_op, opd_pkg::OPD_OP_COPY_ACC_TO_X);
        @(negedge clock);
        u_opd_mem_model.idle();
        check("op", dec_op, opd_pkg::OPD_OP_PUSH_Y_INDEX);
        $display("unassigned and back-to-back done");
    endtask
    task automatic t_halt_stop();
        dec(8'hcb, opd_pkg::OPD_OP_HALT_UNTIL_IRQ);
        check("halted", 8'(halted), 8'h01);
        @(negedge clock);
        u_opd_mem_model.put(8'haa);
        @(negedge clock);
        u_opd_mem_model.idle();
        irq_pending = 1'b1;
        check("refused", 8'(dec_valid), 8'h00);
        @(negedge clock);
        irq_pending = 1'b0;
        check("halted", 8'(halted), 8'h00);
        dec(8'hdb, opd_pkg::OPD_OP_STOP_UNTIL_RESET);
        check("stopped", 8'(stopped), 8'h01);
        @(negedge clock);
        u_opd_mem_model.put(8'haa);
        irq_pending = 1'b1;
        @(negedge clock);
        u_opd_mem_model.idle();
        irq_pending = 1'b0;
        check("refused", 8'(dec_valid), 8'h00);
        check("stopped", 8'(stopped), 8'h01);
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        check("stopped", 8'(stopped), 8'h00);
        check("op", dec_op, opd_pkg::OPD_OP_NOP);
        $display("halt and stop done");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        t_regs();
        t_mem();
        t_nop();
        t_halt_stop();
        summarize();
    end
endmodule
bind opd_decoder opd_properties u_opd_properties (.clock(clock), .rst_n(rst_n),
    .fetch_valid(fetch_valid), .opcode(opcode), .irq_pending(irq_pending),
    .dec_valid(dec_valid), .dec_op(dec_op), .dec_mode(dec_mode), .dec_row(dec_row),
    .dec_col(dec_col), .halted(halted), .stopped(stopped));

//--- opd_mem_model.sv
// Program memory model that presents fetched codes
`timescale 1ns/1ps
module opd_mem_model (
    // Fetch side
    output logic fetch_valid = 1'b0,
    output logic [7:0] opcode = 8'h00
);
    // ==========================================
    // Present one code and hold it until the next put or idle
    task automatic put(input logic [7:0] c);
        fetch_valid = 1'b1;
        opcode = c;
    endtask
    // Released bus shows the inverse of the last byte
    task automatic idle();
        fetch_valid = 1'b0;
        opcode = ~opcode;
    endtask
endmodule

//--- opd_pkg.sv
// Constants and types shared by the operation-code decoder files
// Function
// - 0xAA copies accumulator into X
// - 0xA8 copies accumulator into Y
// - 0xBA copies stack pointer into X
// - 0x8A copies X into accumulator
// - 0x9A loads stack pointer from X
// - 0x98 copies Y into accumulator
// - 0xDA pushes X, 0x5A pushes Y
// - 0xFA pulls X, 0x7A pulls Y
// - 0x64/74/9C/9E store a zero byte
// - 0x14/1C test and clear memory bits
// - 0x04/0C test and set memory bits
// - 0x78 sets interrupt disable flag
// - Rotate left codes 2A/26/36/2E/3E
// - Rotate right codes 6A/66/76/6E/7E
// - Subtract with borrow on its nine codes
// - Store accumulator codes, 0x92 zero-page indirect
// - Store X at 86/96/8E
// - Store Y at 84/94/8C
package opd_pkg;

    // ==========================================
    // Operations
    typedef enum logic [7:0] {
        OPD_OP_NOP = 8'h00,
        OPD_OP_COPY_ACC_TO_X = 8'h01,
        OPD_OP_COPY_ACC_TO_Y = 8'h02,
        OPD_OP_COPY_SP_TO_X = 8'h03,
        OPD_OP_COPY_X_TO_ACC = 8'h04,
        OPD_OP_COPY_X_TO_SP = 8'h05,
        OPD_OP_COPY_Y_TO_ACC = 8'h06,
        OPD_OP_PUSH_X_INDEX = 8'h07,
        OPD_OP_PUSH_Y_INDEX = 8'h08,
        OPD_OP_PULL_X_INDEX = 8'h09,
        OPD_OP_PULL_Y_INDEX = 8'h0a,
        OPD_OP_STORE_ZERO = 8'h0b,
        OPD_OP_TEST_AND_CLEAR_BITS = 8'h0c,
        OPD_OP_TEST_AND_SET_BITS = 8'h0d,
        OPD_OP_SET_IRQ_DISABLE = 8'h0e,
        OPD_OP_ROTATE_LEFT = 8'h0f,
        OPD_OP_ROTATE_RIGHT = 8'h10,
        OPD_OP_SUBTRACT_WITH_BORROW = 8'h11,
        OPD_OP_STORE_ACCUMULATOR = 8'h12,
        OPD_OP_STORE_X_INDEX = 8'h13,
        OPD_OP_STORE_Y_INDEX = 8'h14,
        OPD_OP_HALT_UNTIL_IRQ = 8'h15,
        OPD_OP_STOP_UNTIL_RESET = 8'h16,
        OPD_OP_OTHER = 8'h17
    } opd_op_type;

    // ==========================================
    // Addressing modes
    typedef enum logic [3:0] {
        OPD_AM_IMPLIED = 4'h0,
        OPD_AM_ACCUM = 4'h1,
        OPD_AM_STACK = 4'h2,
        OPD_AM_ZP = 4'h3,
        OPD_AM_ZP_X = 4'h4,
        OPD_AM_ZP_Y = 4'h5,
        OPD_AM_ABS = 4'h6,
        OPD_AM_ABS_X = 4'h7,
        OPD_AM_ABS_Y = 4'h8,
        OPD_AM_ZP_IND = 4'h9,
        OPD_AM_ZP_X_IND = 4'ha,
        OPD_AM_ZP_IND_Y = 4'hb,
        OPD_AM_OTHER = 4'hc
    } opd_mode_type;

    // Decoder handshake states
    typedef enum logic [2:0] {
        OPD_ST_RUN = 3'b001,
        OPD_ST_HALT = 3'b010,
        OPD_ST_STOP = 3'b100
    } opd_state_type;

    localparam logic [7:0] OPD_RESET_OPCODE = 8'hea;
    localparam int OPD_NIBBLE_W = 4;
endpackage

//--- opd_properties.sv
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
module opd_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Fetch side
    input wire logic fetch_valid,
    input wire logic [7:0] opcode,
    input wire logic irq_pending,
    // Decoded outputs
    input wire logic dec_valid,
    input wire opd_pkg::opd_op_type dec_op,
    input wire opd_pkg::opd_mode_type dec_mode,
    input wire logic [3:0] dec_row,
    input wire logic [3:0] dec_col,
    input wire logic halted,
    input wire logic stopped
);
    // ==========================================
    // Decode timing and content
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic take;
    // A code is taken only while running
    assign take = fetch_valid && !halted && !stopped;
    property p_answer;
        take |=> dec_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_quiet;
        !take |=> !dec_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
    property p_rowcol;
        take |=> dec_row == $past(opcode[7:4]) && dec_col == $past(opcode[3:0]);
    endproperty
    a_rowcol: assert property (p_rowcol) else $error("row or column");
    property p_copy;
        take && opcode == 8'haa |=> dec_op == opd_pkg::OPD_OP_COPY_ACC_TO_X;
    endproperty
    a_copy: assert property (p_copy) else $error("copy code");
    property p_nop;
        take && opcode[3:0] == 4'h3 |=> dec_op == opd_pkg::OPD_OP_NOP;
    endproperty
    a_nop: assert property (p_nop) else $error("unassigned code");
    property p_halt;
        take && opcode == 8'hcb |=> halted && !stopped;
    endproperty
    a_halt: assert property (p_halt) else $error("halt");
    property p_stop;
        take && opcode == 8'hdb |=> stopped [*3];
    endproperty
    a_stop: assert property (p_stop) else $error("stop");
    property p_wake;
        halted && irq_pending |=> !halted;
    endproperty
    a_wake: assert property (p_wake) else $error("wake");
    property p_clear_mode;
        take && opcode == 8'h14 |=> dec_op == opd_pkg::OPD_OP_TEST_AND_CLEAR_BITS &&
            dec_mode == opd_pkg::OPD_AM_ZP;
    endproperty
    a_clear_mode: assert property (p_clear_mode) else $error("clear bits mode");
    property p_push;
        take && opcode == 8'hda |=> dec_op == opd_pkg::OPD_OP_PUSH_X_INDEX &&
            dec_mode == opd_pkg::OPD_AM_STACK;
    endproperty
    a_push: assert property (p_push) else $error("push code");
endmodule

//--- opd_row_col.sv
// Splits an operation code into matrix row and column
`timescale 1ns/1ps
module opd_row_col (
    // Operation code
    input wire logic [7:0] opcode,
    // Matrix position
    output logic [opd_pkg::OPD_NIBBLE_W-1:0] row,
    output logic [opd_pkg::OPD_NIBBLE_W-1:0] col
);
    // High nibble row, low nibble column
    assign row = opcode[7:4];
    assign col = opcode[3:0];
endmodule

//--- opd_table.sv
// Combinational lookup of operation and addressing mode by row and column
`timescale 1ns/1ps
module opd_table (
    // Matrix position
    input wire logic [3:0] row,
    input wire logic [3:0] col,
    // Decoded result
    output opd_pkg::opd_op_type op,
    output opd_pkg::opd_mode_type mode
);
    // Per-code lookup of operation, then mode by column
    always_comb begin
        op = opd_pkg::OPD_OP_NOP;
        mode = opd_pkg::OPD_AM_IMPLIED;
        case ({row, col})
            8'haa: op = opd_pkg::OPD_OP_COPY_ACC_TO_X;
            8'ha8: op = opd_pkg::OPD_OP_COPY_ACC_TO_Y;
            8'hba: op = opd_pkg::OPD_OP_COPY_SP_TO_X;
            8'h8a: op = opd_pkg::OPD_OP_COPY_X_TO_ACC;
            8'h9a: op = opd_pkg::OPD_OP_COPY_X_TO_SP;
            8'h98: op = opd_pkg::OPD_OP_COPY_Y_TO_ACC;
            8'h78: op = opd_pkg::OPD_OP_SET_IRQ_DISABLE;
            8'hcb: op = opd_pkg::OPD_OP_HALT_UNTIL_IRQ;
            8'hdb: op = opd_pkg::OPD_OP_STOP_UNTIL_RESET;
            8'hda: begin
                op = opd_pkg::OPD_OP_PUSH_X_INDEX;
                mode = opd_pkg::OPD_AM_STACK;
            end
            8'h5a: begin
                op = opd_pkg::OPD_OP_PUSH_Y_INDEX;
                mode = opd_pkg::OPD_AM_STACK;
            end
            8'hfa: begin
                op = opd_pkg::OPD_OP_PULL_X_INDEX;
                mode = opd_pkg::OPD_AM_STACK;
            end
            8'h7a: begin
                op = opd_pkg::OPD_OP_PULL_Y_INDEX;
                mode = opd_pkg::OPD_AM_STACK;
            end
            8'h64, 8'h74, 8'h9c, 8'h9e: op = opd_pkg::OPD_OP_STORE_ZERO;
            8'h14, 8'h1c: op = opd_pkg::OPD_OP_TEST_AND_CLEAR_BITS;
            8'h04, 8'h0c: op = opd_pkg::OPD_OP_TEST_AND_SET_BITS;
            8'h2a, 8'h26, 8'h36, 8'h2e, 8'h3e: op = opd_pkg::OPD_OP_ROTATE_LEFT;
            8'h6a, 8'h66, 8'h76, 8'h6e, 8'h7e: op = opd_pkg::OPD_OP_ROTATE_RIGHT;
            8'he1, 8'he5, 8'he9, 8'hed, 8'hf1, 8'hf2, 8'hf5, 8'hf9, 8'hfd:
                op = opd_pkg::OPD_OP_SUBTRACT_WITH_BORROW;
            8'h81, 8'h85, 8'h8d, 8'h91, 8'h92, 8'h95, 8'h99, 8'h9d:
                op = opd_pkg::OPD_OP_STORE_ACCUMULATOR;
            8'h86, 8'h96, 8'h8e: op = opd_pkg::OPD_OP_STORE_X_INDEX;
            8'h84, 8'h94, 8'h8c: op = opd_pkg::OPD_OP_STORE_Y_INDEX;
            default: op = opd_pkg::OPD_OP_NOP;
        endcase
        // Mode by column pattern for memory operations
        if (op != opd_pkg::OPD_OP_NOP && mode != opd_pkg::OPD_AM_STACK) begin
            case (col)
                4'h1: mode = row[0] ? opd_pkg::OPD_AM_ZP_IND_Y : opd_pkg::OPD_AM_ZP_X_IND;
                4'h2: mode = opd_pkg::OPD_AM_ZP_IND;
                // Test-and-clear sits in an odd row but is never indexed
                4'h4, 4'h5: begin
                    mode = (row[0] && op != opd_pkg::OPD_OP_TEST_AND_CLEAR_BITS) ?
                        opd_pkg::OPD_AM_ZP_X : opd_pkg::OPD_AM_ZP;
                end
                4'h6: begin
                    if (row[0]) begin
                        mode = (op == opd_pkg::OPD_OP_STORE_X_INDEX) ?
                            opd_pkg::OPD_AM_ZP_Y : opd_pkg::OPD_AM_ZP_X;
                    end else begin
                        mode = opd_pkg::OPD_AM_ZP;
                    end
                end
                4'h9: mode = row[0] ? opd_pkg::OPD_AM_ABS_Y : opd_pkg::OPD_AM_IMPLIED;
                4'ha: mode = (op == opd_pkg::OPD_OP_ROTATE_LEFT ||
                    op == opd_pkg::OPD_OP_ROTATE_RIGHT) ?
                    opd_pkg::OPD_AM_ACCUM : opd_pkg::OPD_AM_IMPLIED;
                4'hc, 4'hd: begin
                    mode = (row[0] && op != opd_pkg::OPD_OP_TEST_AND_CLEAR_BITS) ?
                        opd_pkg::OPD_AM_ABS_X : opd_pkg::OPD_AM_ABS;
                end
                4'he: mode = row[0] ? opd_pkg::OPD_AM_ABS_X : opd_pkg::OPD_AM_ABS;
                default: mode = opd_pkg::OPD_AM_IMPLIED;
            endcase
            // Store zero at 0x9c is absolute, not indexed
            if (row == 4'h9 && col == 4'hc) begin
                mode = opd_pkg::OPD_AM_ABS;
            end
        end
        if (row == 4'he && col == 4'h9) begin
            mode = opd_pkg::OPD_AM_OTHER; // Immediate operand
        end
    end
endmodule
